// *** srp_defines.vh ***
// Offsets, report layout, field positions and codes for the settings readout
`ifndef SRP_DEFINES_VH
`define SRP_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on the register port)
// ----------------------------------------------------------------------
`define SRP_ADDR_W        8
`define SRP_OFF_EDGE_REF  8'h00
`define SRP_OFF_VID_LO    8'h01
`define SRP_OFF_VID_HI    8'h02
`define SRP_OFF_PID_LO    8'h03
`define SRP_OFF_PID_HI    8'h04
`define SRP_OFF_ATTR      8'h05
`define SRP_OFF_CURR      8'h06
`define SRP_OFF_PIN0      8'h08
`define SRP_OFF_STATUS    8'h10
`define SRP_OFF_APPLY     8'h11
`define SRP_WIN_CHIP      2'h1
`define SRP_WIN_PIN       2'h2

// ----------------------------------------------------------------------
// Report layout
// ----------------------------------------------------------------------
`define SRP_RPT_CMD       8'hB0
`define SRP_RPT_OK        8'h00
`define SRP_IDX_CMD       6'h00
`define SRP_IDX_CODE      6'h01
`define SRP_IDX_LEN       6'h02
`define SRP_IDX_CS7       6'h07
`define SRP_IDX_VID_LO    6'h08
`define SRP_IDX_VID_HI    6'h09
`define SRP_IDX_PID_LO    6'h0A
`define SRP_IDX_PID_HI    6'h0B
`define SRP_IDX_ATTR      6'h0C
`define SRP_IDX_CURR      6'h0D
`define SRP_IDX_PIN0      6'h04
`define SRP_IDX_PIN3      6'h07

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SRP_BIT_FALL_EN   6
`define SRP_BIT_RISE_EN   5
`define SRP_BIT_ADC_HI    4
`define SRP_BIT_ADC_LO    3
`define SRP_BIT_DAC_SUPPLY 2
`define SRP_BIT_OUT_VAL   4
`define SRP_BIT_DIR_IN    3
`define SRP_BIT_STAT_FLAG 0

// ----------------------------------------------------------------------
// Pin function codes
// ----------------------------------------------------------------------
`define SRP_FN_GPIO       3'h0
`define SRP_FN_DEDIC      3'h1
`define SRP_FN_ALT0       3'h2
`define SRP_FN_ALT1       3'h3
`define SRP_FN_ALT2       3'h4

// ----------------------------------------------------------------------
// Analog reference codes
// ----------------------------------------------------------------------
`define SRP_REF_OFF       2'h0
`define SRP_REF_1V024     2'h1
`define SRP_REF_2V048     2'h2
`define SRP_REF_4V096     2'h3

`endif

// *** srp_settings_readout.v ***
// Stored power-up settings, their 64-byte report images and pin setup
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "srp_defines.vh"

// Overview of operation
// - A falling edge on the edge pin sets the flag when fall detect is on.
// - A rising edge sets the flag when rise detect is on; both may be on.
// - Byte 7 bits 4-3 pick a 4.096, 2.048 or 1.024 V reference, or none.
// - Byte 7 bit 2 picks the supply (one) or the internal reference (zero).
// - Settings bytes 8 and 9 carry the vendor identifier, low byte first.
// - Bytes 10 and 11 carry the product identifier, low byte first.
// - Byte 12 is the enumeration attributes value and is also reported.
// - The requested current is byte 13 times two milliamperes.
// - Pin report bytes 0-3: command echo, success code, length, free byte.
// - Bytes 4 to 6 hold pins zero to two; a general output drives bit 4.
// - Bit 3 is the direction, one meaning input, in general mode only.
// - Pin zero: general, suspend, receive light; other codes ignored.
// - Pin one: general, clock, analog in, transmit light, edge detect.
// - Pin two: general, bus configured, analog in two, analog out one.
// - Pin three, byte 7: general, traffic light, analog in, analog out.
module srp_settings_readout #(
   parameter [7:0]  CS7_RST     = 8'h00,
   parameter [15:0] VID_RST     = 16'h0000, // Arbitrary neutral value
   parameter [15:0] PID_RST     = 16'h0000, // Arbitrary neutral value
   parameter [7:0]  ATTR_RST    = 8'h80,
   parameter [7:0]  CURR_RST    = 8'h32,
   parameter [7:0]  PIN_RST     = 8'h08,
   parameter [7:0]  CHIP_LEN    = 8'h0E,
   parameter [7:0]  PIN_LEN     = 8'h08
) (
   // Clock and reset
   input  wire        mclk,
   input  wire        srst,
   // Register port
   input  wire [7:0]  addr,
   input  wire [7:0]  wdata,
   input  wire        wr_stb,
   input  wire        rd_stb,
   output reg  [7:0]  rdata_q,
   // Pin pads and sources for the alternate functions
   input  wire [3:0]  pin_in,
   input  wire        suspend_indicator,
   input  wire        receive_activity_light,
   input  wire        clock_out_src,
   input  wire        transmit_activity_light,
   input  wire        bus_configured_indicator,
   input  wire        bus_traffic_light,
   output reg  [3:0]  pin_out_q,
   output reg  [3:0]  pin_oe_q,
   // Analog routing: input bit 0 pin one ... bit 2 pin three; output bit 0 pin two, bit 1 pin three
   output reg  [2:0]  analog_input_en_q,
   output reg  [1:0]  analog_output_en_q,
   output reg  [1:0]  adc_ref_sel_q,
   output reg         dac_ref_supply_q,
   // Enumeration values and edge detection
   output reg  [15:0] vid_q,
   output reg  [15:0] pid_q,
   output reg  [7:0]  usb_attr_q,
   output reg  [8:0]  usb_current_ma_q,
   output reg         int_flag_q
);

   // ----------------------------------------------------------------------
   // Stored settings and active pin configuration
   // ----------------------------------------------------------------------
   reg  [7:0]  cs7_q;
   reg  [7:0]  vid_lo_q;
   reg  [7:0]  vid_hi_q;
   reg  [7:0]  pid_lo_q;
   reg  [7:0]  pid_hi_q;
   reg  [7:0]  attr_q;
   reg  [7:0]  curr_q;
   reg  [7:0]  pin_set_q [0:3];
   reg  [7:0]  pin_act_q [0:3];
   reg         load_q;
   reg  [3:0]  sync1_q;
   reg  [3:0]  sync2_q;
   reg         edge_prev_q;
   reg  [3:0]  pin_out_d;
   reg  [3:0]  pin_oe_d;
   reg  [2:0]  ain_d;
   reg  [1:0]  aout_d;
   reg  [7:0]  rpt_byte;
   reg  [7:0]  rdata_d;
   wire        apply_wr;
   wire        flag_clr;
   wire        edge_en;
   wire        rise_seen;
   wire        fall_seen;
   wire        pin_hit;
   wire [5:0]  idx;
   integer     i, j, m;

   assign apply_wr = wr_stb && (addr == `SRP_OFF_APPLY);
   assign flag_clr = wr_stb && (addr == `SRP_OFF_STATUS) &&
                     wdata[`SRP_BIT_STAT_FLAG];
   assign idx      = addr[5:0];
   assign pin_hit  = ((addr & 8'hFC) == `SRP_OFF_PIN0);

   // Software writes to the stored settings
   always @(posedge mclk) begin
      if (srst) begin
         cs7_q    <= CS7_RST;
         vid_lo_q <= VID_RST[7:0];
         vid_hi_q <= VID_RST[15:8];
         pid_lo_q <= PID_RST[7:0];
         pid_hi_q <= PID_RST[15:8];
         attr_q   <= ATTR_RST;
         curr_q   <= CURR_RST;
         for (i = 0; i < 4; i = i + 1)
            pin_set_q[i] <= PIN_RST;
      end else if (wr_stb) begin
         case (addr)
            `SRP_OFF_EDGE_REF: cs7_q    <= wdata;
            `SRP_OFF_VID_LO:   vid_lo_q <= wdata;
            `SRP_OFF_VID_HI:   vid_hi_q <= wdata;
            `SRP_OFF_PID_LO:   pid_lo_q <= wdata;
            `SRP_OFF_PID_HI:   pid_hi_q <= wdata;
            `SRP_OFF_ATTR:     attr_q   <= wdata;
            `SRP_OFF_CURR:     curr_q   <= wdata;
            default: if (pin_hit) pin_set_q[addr[1:0]] <= wdata;
         endcase
      end
   end

   // Pin setup is taken from the stored bytes only on the cycle after reset
   // or on an explicit apply, so edits to stored values never glitch pins
   always @(posedge mclk) begin
      if (srst) begin
         load_q <= 1'b1;
         for (j = 0; j < 4; j = j + 1)
            pin_act_q[j] <= PIN_RST;
      end else begin
         load_q <= 1'b0;
         if (load_q || apply_wr) begin
            for (j = 0; j < 4; j = j + 1)
               pin_act_q[j] <= pin_set_q[j];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Pin input synchroniser and edge detection
   // ----------------------------------------------------------------------
   // Runs through reset so the edge history matches the pad, no false edge
   always @(posedge mclk) begin
      sync1_q     <= pin_in;
      sync2_q     <= sync1_q;
      edge_prev_q <= sync2_q[1];
   end

   // Edge detect lives on pin one
   assign edge_en   = (pin_act_q[1][2:0] == `SRP_FN_ALT2);
   assign rise_seen = edge_en && cs7_q[`SRP_BIT_RISE_EN] &&
                      sync2_q[1] && !edge_prev_q;
   assign fall_seen = edge_en && cs7_q[`SRP_BIT_FALL_EN] &&
                      !sync2_q[1] && edge_prev_q;

   // Sticky flag; a new edge beats a clear in the same cycle
   always @(posedge mclk) begin
      if (srst) begin
         int_flag_q <= 1'b0;
      end else if (rise_seen || fall_seen) begin
         int_flag_q <= 1'b1;
      end else if (flag_clr) begin
         int_flag_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Pin function multiplexing
   // ----------------------------------------------------------------------
   // Ignored function codes leave the pin undriven rather than guessing
   always @* begin
      pin_out_d = 4'h0;
      pin_oe_d  = 4'h0;
      ain_d     = 3'h0;
      aout_d    = 2'h0;
      // General output drives the stored level
      // Direction bit counts only in general mode
      for (m = 0; m < 4; m = m + 1)
         if (pin_act_q[m][2:0] == `SRP_FN_GPIO) begin
            pin_out_d[m] = pin_act_q[m][`SRP_BIT_OUT_VAL];
            pin_oe_d[m]  = !pin_act_q[m][`SRP_BIT_DIR_IN];
         end
      case (pin_act_q[0][2:0])
         `SRP_FN_DEDIC: begin
            pin_out_d[0] = suspend_indicator;
            pin_oe_d[0]  = 1'b1;
         end
         `SRP_FN_ALT0: begin
            pin_out_d[0] = receive_activity_light;
            pin_oe_d[0]  = 1'b1;
         end
         default: ;
      endcase
      case (pin_act_q[1][2:0])
         `SRP_FN_DEDIC: begin
            pin_out_d[1] = clock_out_src;
            pin_oe_d[1]  = 1'b1;
         end
         `SRP_FN_ALT0: ain_d[0] = 1'b1;
         `SRP_FN_ALT1: begin
            pin_out_d[1] = transmit_activity_light;
            pin_oe_d[1]  = 1'b1;
         end
         default: ;
      endcase
      case (pin_act_q[2][2:0])
         `SRP_FN_DEDIC: begin
            pin_out_d[2] = bus_configured_indicator;
            pin_oe_d[2]  = 1'b1;
         end
         `SRP_FN_ALT0: ain_d[1]  = 1'b1;
         `SRP_FN_ALT1: aout_d[0] = 1'b1;
         default: ;
      endcase
      case (pin_act_q[3][2:0])
         `SRP_FN_DEDIC: begin
            pin_out_d[3] = bus_traffic_light;
            pin_oe_d[3]  = 1'b1;
         end
         `SRP_FN_ALT0: ain_d[2]  = 1'b1;
         `SRP_FN_ALT1: aout_d[1] = 1'b1;
         default: ;
      endcase
   end

   // Registered pin and analog outputs, plus decoded enumeration values
   always @(posedge mclk) begin
      if (srst) begin
         pin_out_q          <= 4'h0;
         pin_oe_q           <= 4'h0;
         analog_input_en_q  <= 3'h0;
         analog_output_en_q <= 2'h0;
         adc_ref_sel_q      <= `SRP_REF_OFF;
         dac_ref_supply_q   <= 1'b0;
         vid_q              <= 16'h0000;
         pid_q              <= 16'h0000;
         usb_attr_q         <= 8'h00;
         usb_current_ma_q   <= 9'h000;
      end else begin
         pin_out_q          <= pin_out_d;
         pin_oe_q           <= pin_oe_d;
         analog_input_en_q  <= ain_d;
         analog_output_en_q <= aout_d;
         adc_ref_sel_q      <= cs7_q[`SRP_BIT_ADC_HI:`SRP_BIT_ADC_LO];
         dac_ref_supply_q   <= cs7_q[`SRP_BIT_DAC_SUPPLY];
         vid_q              <= {vid_hi_q, vid_lo_q};
         pid_q              <= {pid_hi_q, pid_lo_q};
         usb_attr_q         <= attr_q;
         // Current in milliamperes is twice the stored byte
         usb_current_ma_q   <= {curr_q, 1'b0};
      end
   end

   // ----------------------------------------------------------------------
   // Report images and register readback
   // ----------------------------------------------------------------------
   // Report bytes come from the stored settings, not the active copy,
   // so a host sees what the next apply will load
   always @* begin
      rpt_byte = 8'h00;
      if (idx == `SRP_IDX_CMD) begin
         rpt_byte = `SRP_RPT_CMD;
      end else if (idx == `SRP_IDX_CODE) begin
         rpt_byte = `SRP_RPT_OK;
      end else if (addr[7:6] == `SRP_WIN_CHIP) begin
         case (idx)
            `SRP_IDX_LEN:    rpt_byte = CHIP_LEN;
            `SRP_IDX_CS7:    rpt_byte = cs7_q;
            `SRP_IDX_VID_LO: rpt_byte = vid_lo_q;
            `SRP_IDX_VID_HI: rpt_byte = vid_hi_q;
            `SRP_IDX_PID_LO: rpt_byte = pid_lo_q;
            `SRP_IDX_PID_HI: rpt_byte = pid_hi_q;
            `SRP_IDX_ATTR:   rpt_byte = attr_q;
            `SRP_IDX_CURR:   rpt_byte = curr_q;
            default:         rpt_byte = 8'h00;
         endcase
      end else begin
         if (idx == `SRP_IDX_LEN) begin
            rpt_byte = PIN_LEN;
         // Pin bytes at report positions four to seven
         end else if (idx >= `SRP_IDX_PIN0 && idx <= `SRP_IDX_PIN3) begin
            rpt_byte = pin_set_q[idx[1:0]];
         end
      end
   end

   // Read data valid only in the cycle after the read strobe
   always @* begin
      rdata_d = 8'h00;
      if (addr[7:6] == `SRP_WIN_CHIP || addr[7:6] == `SRP_WIN_PIN) begin
         rdata_d = rpt_byte;
      end else begin
         case (addr)
            `SRP_OFF_EDGE_REF: rdata_d = cs7_q;
            `SRP_OFF_VID_LO:   rdata_d = vid_lo_q;
            `SRP_OFF_VID_HI:   rdata_d = vid_hi_q;
            `SRP_OFF_PID_LO:   rdata_d = pid_lo_q;
            `SRP_OFF_PID_HI:   rdata_d = pid_hi_q;
            `SRP_OFF_ATTR:     rdata_d = attr_q;
            `SRP_OFF_CURR:     rdata_d = curr_q;
            `SRP_OFF_STATUS:   rdata_d = {sync2_q, 3'h0, int_flag_q};
            default: if (pin_hit) rdata_d = pin_set_q[addr[1:0]];
         endcase
      end
   end

   // Read data stands for one cycle only, so a stale value never lingers
   always @(posedge mclk) begin
      rdata_q <= (rd_stb && !srst) ? rdata_d : 8'h00;
   end

endmodule
`default_nettype wire

// *** srp_settings_readout_properties.sv ***
// Port-level assertions for the settings readout
`timescale 1ns/1ps
`default_nettype none
`include "srp_defines.vh"
// ----------------------------------------------------------------
// Checker
// ----------------------------------------------------------------
module srp_settings_readout_properties #(
   parameter [7:0] PIN_LEN = 8'h08
) (
   // Clock, reset and register port
   input wire logic        mclk,
   input wire logic        srst,
   input wire logic [7:0]  addr,
   input wire logic [7:0]  wdata,
   input wire logic        wr_stb,
   input wire logic        rd_stb,
   input wire logic [7:0]  rdata_q,
   // Decoded settings
   input wire logic [15:0] vid_q,
   input wire logic [15:0] pid_q,
   input wire logic [7:0]  usb_attr_q,
   input wire logic [8:0]  usb_current_ma_q,
   input wire logic [1:0]  adc_ref_sel_q,
   input wire logic        dac_ref_supply_q,
   input wire logic        int_flag_q
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   // Read of either report window
   wire logic rd_rpt = rd_stb && ^addr[7:6];
   a_idle_zero: assert property (!rd_stb |=> rdata_q == 8'h00)
      else $error("read data not zero when idle");
   a_cmd_echo: assert property (rd_rpt && addr[5:0] == 6'h00
      |=> rdata_q == `SRP_RPT_CMD) else $error("no command echo");
   a_ok_code: assert property (rd_rpt && addr[5:0] == 6'h01
      |=> rdata_q == `SRP_RPT_OK) else $error("no success code");
   a_pin_len: assert property (rd_stb && addr == 8'h82
      |=> rdata_q == PIN_LEN) else $error("pin length wrong");
   a_chip_tail: assert property (rd_stb && addr[7:6] == 2'b01
      && addr[5:0] > 6'h0D |=> rdata_q == 8'h00) else $error("tail set");
   a_vid_low: assert property (rd_stb && addr == 8'h48
      |=> rdata_q == vid_q[7:0]) else $error("vid low byte wrong");
   a_pid_high: assert property (rd_stb && addr == 8'h4B
      |=> rdata_q == pid_q[15:8]) else $error("pid high byte wrong");
   a_attr_echo: assert property (rd_stb && addr == 8'h4C
      |=> rdata_q == usb_attr_q) else $error("attributes differ");
   a_current_x2: assert property (rd_stb && addr == `SRP_OFF_CURR
      |=> usb_current_ma_q == {rdata_q, 1'b0}) else $error("current wrong");
   a_ref_decode: assert property (rd_stb && addr == 8'h00
      |=> adc_ref_sel_q == rdata_q[4:3] && dac_ref_supply_q == rdata_q[2])
      else $error("reference select wrong");
   a_flag_sticky: assert property (int_flag_q && !(wr_stb && wdata[0]
      && addr == `SRP_OFF_STATUS) |=> int_flag_q) else $error("flag lost");
   // Main scenarios
   c_pin_rpt: cover property (rd_stb && addr == 8'h84);
   c_flag: cover property ($rose(int_flag_q));
   c_apply: cover property (wr_stb && addr == `SRP_OFF_APPLY);
endmodule
bind srp_settings_readout srp_settings_readout_properties #(
   .PIN_LEN(PIN_LEN)) u_props (.mclk(mclk), .srst(srst), .addr(addr),
   .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q),
   .vid_q(vid_q), .pid_q(pid_q), .usb_attr_q(usb_attr_q),
   .usb_current_ma_q(usb_current_ma_q), .adc_ref_sel_q(adc_ref_sel_q),
   .dac_ref_supply_q(dac_ref_supply_q), .int_flag_q(int_flag_q));
`default_nettype wire

// *** srp_host_model.sv ***
// Register-port master standing in for the configuring host
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Host model
// ----------------------------------------------------------------
module srp_host_model (
   // Clock
   input  wire logic       mclk,
   // Register port, master side
   output var  logic [7:0] addr,
   output var  logic [7:0] wdata,
   output var  logic       wr_stb,
   output var  logic       rd_stb,
   input  wire logic [7:0] rdata_q
);
   // Idle bus before the first request
   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
   end
   // One write cycle; lines are inverted after, so stale data never matches
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge mclk);
      addr <= ~a;
      wdata <= ~d;
      wr_stb <= 1'b0;
   endtask
   // One read cycle; data is taken at the edge closing the cycle it stands in
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      addr <= ~a;
      rd_stb <= 1'b0;
      @(posedge mclk);
      d = rdata_q;
   endtask
endmodule
`default_nettype wire

// *** srp_settings_readout_test.sv ***
// Self-checking bench for the settings readout
`timescale 1ns/1ps
`default_nettype none
`include "srp_defines.vh"
// ----------------------------------------------------------------
// Bench
// ----------------------------------------------------------------
module srp_settings_readout_test;
   localparam [7:0] ATTR = 8'h80, CURR = 8'h32, PINR = 8'h08;
   localparam [7:0] CLEN = 8'h0E, PLEN = 8'h08;
   logic        mclk = 1'b0;
   logic        srst = 1'b1;
   logic [3:0]  pin_in = 4'h0;
   logic [5:0]  src = 6'h00;
   wire  [7:0]  addr, wdata, rdata_q, usb_attr_q;
   wire         wr_stb, rd_stb, dac_ref_supply_q, int_flag_q;
   wire  [3:0]  pin_out_q, pin_oe_q;
   wire  [2:0]  ain;
   wire  [1:0]  aout, adc_ref_sel_q;
   wire  [15:0] vid_q, pid_q;
   wire  [8:0]  cur;
   int          num_errors = 0, cmp_count = 0, seed = 32'he4512fa0;
   int          n, k, p;
   logic [7:0]  d, cs[0:6], pb[0:3];
   logic [1:0]  e;
   logic        x;
   always #2.5 mclk = ~mclk;
   srp_settings_readout #(.ATTR_RST(ATTR), .CURR_RST(CURR), .PIN_RST(PINR),
      .CHIP_LEN(CLEN), .PIN_LEN(PLEN)) DUT (.mclk(mclk), .srst(srst),
      .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rdata_q(rdata_q), .pin_in(pin_in), .suspend_indicator(src[0]),
      .receive_activity_light(src[1]), .clock_out_src(src[2]),
      .transmit_activity_light(src[3]), .bus_configured_indicator(src[4]),
      .bus_traffic_light(src[5]), .pin_out_q(pin_out_q),
      .pin_oe_q(pin_oe_q), .analog_input_en_q(ain),
      .analog_output_en_q(aout), .adc_ref_sel_q(adc_ref_sel_q),
      .dac_ref_supply_q(dac_ref_supply_q), .vid_q(vid_q), .pid_q(pid_q),
      .usb_attr_q(usb_attr_q), .usb_current_ma_q(cur),
      .int_flag_q(int_flag_q));
   srp_host_model host (.mclk(mclk), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q));
   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] ex);
      host.rd(a, d);
      check(d, ex);
   endtask
   task automatic results;
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Expected pad enable and level of one pin; ignored codes leave it off
   function automatic logic [1:0] pin_exp(input int q, input logic [7:0] b);
      logic [2:0] f;
      f = b[2:0];
      if (f == 3'h0)
         return {!b[3], b[4]};
      if (q == 0 && (f == 3'h1 || f == 3'h2))
         return {1'b1, src[f - 3'h1]};
      if (q == 1 && (f == 3'h1 || f == 3'h3))
         return {1'b1, (f == 3'h1) ? src[2] : src[3]};
      if (q >= 2 && f == 3'h1)
         return {1'b1, src[q + 2]};
      return 2'b00;
   endfunction
   // Cut a hang short
   initial begin
      #200000;
      num_errors++;
      results;
   end
   initial begin
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      for (k = 0; k < 2; k++) begin
         rdchk(`SRP_OFF_ATTR, ATTR);
         rdchk(`SRP_OFF_CURR, CURR);
         rdchk(8'h82, PLEN);
         rdchk(8'h42, CLEN);
         rdchk(8'h87, PINR);
         rdchk(8'hC5, 8'h00);
         check(pin_oe_q, {4{~PINR[3]}});
         host.wr(`SRP_OFF_CURR, 8'h11);
         @(posedge mclk);
         srst <= 1'b1;
         repeat (2) @(posedge mclk);
         srst <= 1'b0;
      end
      // Chip settings: corner values first, then random
      for (k = 0; k < 6; k++) begin
         for (n = 0; n < 7; n++) begin
            cs[n] = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($random(seed));
            if (n == 0)
               cs[0][4:3] = 2'(k);
            host.wr(8'(n), cs[n]);
         end
         host.wr(8'hC3, 8'h5A);
         for (n = 0; n < 7; n++) begin
            rdchk(8'h47 + 8'(n), cs[n]);
            rdchk(8'(n), cs[n]);
         end
         rdchk(8'h4E + 8'(k), 8'h00);
         check(vid_q, {cs[2], cs[1]});
         check(pid_q, {cs[4], cs[3]});
         check(usb_attr_q, cs[5]);
         check(cur, {cs[6], 1'b0});
         check(adc_ref_sel_q, cs[0][4:3]);
         check(dac_ref_supply_q, cs[0][2]);
      end
      // Pin setup: every function code on every pin
      for (k = 0; k < 8; k++) begin
         for (p = 0; p < 4; p++) begin
            pb[p] = {3'h0, 2'($random(seed)), 3'((k + p) % 8)};
            host.wr(8'h08 + 8'(p), pb[p]);
         end
         src <= 6'($random(seed));
         pin_in <= 4'($random(seed));
         host.wr(`SRP_OFF_APPLY, 8'h01);
         repeat (3) @(posedge mclk);
         for (p = 0; p < 4; p++) begin
            e = pin_exp(p, pb[p]);
            check(pin_oe_q[p], e[1]);
            if (e[1])
               check(pin_out_q[p], e[0]);
         end
         for (p = 1; p < 4; p++)
            check(ain[p - 1], pb[p][2:0] == 3'h2);
         check(aout, {pb[3][2:0] == 3'h3, pb[2][2:0] == 3'h3});
         rdchk(8'h84 + 8'(k % 4), pb[k % 4]);
         rdchk(8'h08 + 8'(k % 4), pb[k % 4]);
         rdchk(8'h88 + 8'(k), 8'h00);
      end
      // Edge detection: rise, fall and both enables against both edges
      host.wr(8'h09, 8'h0C);
      host.wr(`SRP_OFF_APPLY, 8'h01);
      for (k = 0; k < 6; k++) begin
         d = {1'b0, 2'(k / 2 + 1), 5'h00};
         x = k[0] ? d[6] : d[5];
         host.wr(`SRP_OFF_EDGE_REF, 8'h00);
         pin_in[1] <= k[0];
         repeat (4) @(posedge mclk);
         host.wr(`SRP_OFF_STATUS, 8'h01);
         host.wr(`SRP_OFF_EDGE_REF, d);
         pin_in[1] <= ~k[0];
         for (n = 0; n < 8 && int_flag_q !== 1'b1; n++)
            @(posedge mclk);
         check(int_flag_q, x);
         repeat (8) @(posedge mclk);
         rdchk(`SRP_OFF_STATUS, {pin_in, 3'h0, x});
      end
      results;
   end
endmodule
`default_nettype wire
